// ### common/pmcip_pkg.sv
// Shared constants and types for the PCI master configuration and I/O proxy
package pmcip_pkg;
   // Register byte offsets on the plain register port
   localparam logic [7:0] ADR_CMD = 8'h00;
   localparam logic [7:0] ADR_DATA = 8'h04;
   localparam logic [7:0] ADR_ADDR = 8'h08;
   localparam logic [7:0] ADR_STAT = 8'h0C;
   localparam logic [7:0] ADR_LAT = 8'h10;
   // Command register fields
   localparam int CMD_READY_BIT = 31;
   localparam int CMD_TYPE_BIT = 8;
   localparam int CMD_BE_LSB = 4;
   localparam int CMD_RDWR_BIT = 0;
   localparam logic TYPE_CFG = 1'b0;
   localparam logic TYPE_IO = 1'b1;
   // Status register bits, write one to clear
   localparam int ST_MABORT = 0;
   localparam int ST_TABORT = 1;
   localparam int ST_RETRY = 2;
   localparam int ST_DISC = 3;
   localparam int ST_LATTMO = 4;
   localparam int ST_PERR = 5;
   localparam int ST_SERR = 6;
   localparam int ST_BEERR = 7;
   localparam int STAT_W = 8;
   // Bus command codes
   localparam logic [3:0] CODE_IO_RD = 4'h2;
   localparam logic [3:0] CODE_IO_WR = 4'h3;
   localparam logic [3:0] CODE_CFG_RD = 4'hA;
   localparam logic [3:0] CODE_CFG_WR = 4'hB;
   localparam logic [3:0] BE_N_NONE = 4'hF;
   // Reset values and link timing in link clock cycles
   localparam logic [7:0] LAT_RESET = 8'h20;
   localparam logic [7:0] DEVSEL_LIMIT = 8'h05;
   localparam logic [7:0] WAIT_MAX = 8'hFF;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   // Bus sequencer states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_REQ = 3'b001,
      ST_ADDR = 3'b010,
      ST_DATA = 3'b011,
      ST_END = 3'b100
   } pmcip_state_type;
endpackage

// ### common/pmcip_pin_if.sv
// Synchronised link pin levels passed from the pin sampler to the core
`timescale 1ns/1ps
interface pmcip_pin_if;
   logic link_rise;
   logic gnt;
   logic bus_idle;
   logic trdy;
   logic devsel;
   logic stop;
   logic perr;
   logic serr;
   logic [31:0] ad;
   modport sync_mp (output link_rise, gnt, bus_idle, trdy, devsel, stop, perr, serr, ad);
   modport core_mp (input link_rise, gnt, bus_idle, trdy, devsel, stop, perr, serr, ad);
endinterface

// ### design/pmcip_pin_sync.sv
// Two-stage sampler for link pins and link clock edge finder
`timescale 1ns/1ps
module pmcip_pin_sync (
   input wire logic clk,
   input wire logic rst,
   input wire logic pci_clk_in,
   input wire logic bus_grant_in_n,
   input wire logic frame_line_i,
   input wire logic initiator_ready_line_i,
   input wire logic target_ready_line_n,
   input wire logic devsel_line_n,
   input wire logic stop_line_n,
   input wire logic parity_error_line_n,
   input wire logic system_error_line_n,
   input wire logic [31:0] ad_i,
   pmcip_pin_if.sync_mp pin
);
   logic [40:0] s1_r;
   logic [40:0] s2_r;
   logic clk_d_r;

   ////////////////////////////////////////////////////////////////////////////
   // First stage feeds only the second; logic reads the second and later
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_r <= 41'h1FF_FFFF_FFFF;
         s2_r <= 41'h1FF_FFFF_FFFF;
         clk_d_r <= 1'b1;
      end else begin
         s1_r <= {pci_clk_in, bus_grant_in_n, frame_line_i, initiator_ready_line_i, target_ready_line_n,
                  devsel_line_n, stop_line_n, parity_error_line_n, system_error_line_n, ad_i};
         s2_r <= s1_r;
         clk_d_r <= s2_r[40];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Rising link edge seen a few fast cycles late, well inside the high half
   assign pin.link_rise = s2_r[40] & ~clk_d_r;
   assign pin.gnt = ~s2_r[39];
   assign pin.bus_idle = s2_r[38] & s2_r[37];
   assign pin.trdy = ~s2_r[36];
   assign pin.devsel = ~s2_r[35];
   assign pin.stop = ~s2_r[34];
   assign pin.perr = ~s2_r[33];
   assign pin.serr = ~s2_r[32];
   assign pin.ad = s2_r[31:0];
endmodule

// ### design/pmcip_cmd_enc.sv
// Command code selection and byte enable legality for a proxy command
`timescale 1ns/1ps
module pmcip_cmd_enc (
   input wire logic io_sel,
   input wire logic rd_sel,
   input wire logic [3:0] be,
   input wire logic [1:0] addr_lsb,
   output logic [3:0] code,
   output logic [3:0] be_n,
   output logic be_ok
);
   // I/O first data phase enables must agree with the low address bits
   function automatic logic io_be_legal(input logic [1:0] a, input logic [3:0] n);
      logic ok;
      ok = (n == pmcip_pkg::BE_N_NONE);
      unique case (a)
         2'h0: ok = ok | (n[0] == 1'b0);
         2'h1: ok = ok | (n[1:0] == 2'h1);
         2'h2: ok = ok | (n[2:0] == 3'h3);
         2'h3: ok = ok | (n == 4'h7);
      endcase
      return ok;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Type bit picks I/O codes; configuration may use any enable mix
   always_comb begin
      be_n = ~be;
      if (io_sel == pmcip_pkg::TYPE_IO) begin
         code = rd_sel ? pmcip_pkg::CODE_IO_RD : pmcip_pkg::CODE_IO_WR;
         be_ok = io_be_legal(addr_lsb, ~be);
      end else begin
         code = rd_sel ? pmcip_pkg::CODE_CFG_RD : pmcip_pkg::CODE_CFG_WR;
         be_ok = 1'b1;
      end
   end
endmodule

// ### design/pmcip_top.sv
// PCI master proxy engine for single data phase configuration and I/O cycles
// Operation
// - Config address bits 31:2 select device, function, dword; bits 1:0 give type.
// - Config byte enables select any bytes of the dword, lane n for byte n.
// - Bus request rises the cycle after a command write is accepted.
// - Config write address phase drives frame, address and code Bh.
// - Config read address phase drives frame, address and code Ah.
// - I/O write address phase drives frame, byte address and code 3h.
// - I/O read address phase drives frame, byte address and code 2h.
// - Next cycle irdy asserts, frame drops, write data driven: one data phase.
// - No initiator wait states; hold the data phase until target ready.
// - Watch master abort, target abort, retry, disconnect, latency, parity, system errors.
// - A finished write sets the ready bit.
// - A finished read stores returned data, then sets ready.
// - I/O uses full byte address; bits 1:0 name lowest valid byte.
// - I/O first phase byte enables must match address bits 1:0.
//
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
module pmcip_top (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic pci_clk_in,
   input wire logic bus_grant_in_n,
   output logic bus_request_out_n,
   input wire logic frame_line_i,
   output logic frame_line_o,
   output logic frame_line_oe_n,
   input wire logic initiator_ready_line_i,
   output logic initiator_ready_line_o,
   output logic initiator_ready_line_oe_n,
   input wire logic target_ready_line_n,
   input wire logic devsel_line_n,
   input wire logic stop_line_n,
   input wire logic parity_error_line_n,
   input wire logic system_error_line_n,
   input wire logic [31:0] ad_i,
   output logic [31:0] ad_o,
   output logic ad_oe_n,
   output logic [3:0] command_byte_enable_lines_o,
   output logic command_byte_enable_lines_oe_n
);
   pmcip_pin_if pin ();
   pmcip_pkg::pmcip_state_type st_r;
   logic [31:0] data_r;
   logic [31:0] addr_r;
   logic type_r;
   logic rd_r;
   logic [3:0] code_r;
   logic [3:0] be_n_r;
   logic ready_r;
   logic [pmcip_pkg::STAT_W-1:0] stat_r;
   logic [pmcip_pkg::STAT_W-1:0] stat_set;
   logic [pmcip_pkg::STAT_W-1:0] stat_clr;
   logic [7:0] lat_r;
   logic [7:0] wait_cnt_r;
   logic req_r;
   logic [3:0] enc_code;
   logic [3:0] enc_be_n;
   logic enc_ok;
   logic cmd_wr;
   logic start;
   logic lr;
   logic term_ok;
   logic term_retry;
   logic term_abort;
   logic ma_hit;
   logic fin;

   pmcip_pin_sync u_sync (
      .clk(clk),
      .rst(rst),
      .pci_clk_in(pci_clk_in),
      .bus_grant_in_n(bus_grant_in_n),
      .frame_line_i(frame_line_i),
      .initiator_ready_line_i(initiator_ready_line_i),
      .target_ready_line_n(target_ready_line_n),
      .devsel_line_n(devsel_line_n),
      .stop_line_n(stop_line_n),
      .parity_error_line_n(parity_error_line_n),
      .system_error_line_n(system_error_line_n),
      .ad_i(ad_i),
      .pin(pin)
   );

   pmcip_cmd_enc u_enc (
      .io_sel(reg_wdata[pmcip_pkg::CMD_TYPE_BIT]),
      .rd_sel(reg_wdata[pmcip_pkg::CMD_RDWR_BIT]),
      .be(reg_wdata[pmcip_pkg::CMD_BE_LSB+:4]),
      .addr_lsb(addr_r[1:0]),
      .code(enc_code),
      .be_n(enc_be_n),
      .be_ok(enc_ok)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Command decode; a command while busy or with bad enables is dropped
   assign cmd_wr = reg_wr && (reg_addr == pmcip_pkg::ADR_CMD);
   assign start = cmd_wr && ready_r && enc_ok;
   assign lr = pin.link_rise;

   // Data phase terminations, judged only at a link edge
   assign term_ok = pin.devsel && pin.trdy;
   assign term_retry = pin.devsel && pin.stop && !pin.trdy;
   assign term_abort = !pin.devsel && pin.stop;
   assign ma_hit = !pin.devsel && (wait_cnt_r >= pmcip_pkg::DEVSEL_LIMIT);
   assign fin = lr && (st_r == pmcip_pkg::ST_DATA) && (term_ok || term_retry || term_abort || ma_hit);

   // Error flags raised during a transfer, and the enable error raised on a refused command
   always_comb begin
      stat_set = '0;
      stat_set[pmcip_pkg::ST_BEERR] = cmd_wr && ready_r && !enc_ok;
      if (lr && (st_r == pmcip_pkg::ST_DATA)) begin
         stat_set[pmcip_pkg::ST_MABORT] = ma_hit && !pin.stop;
         stat_set[pmcip_pkg::ST_TABORT] = term_abort;
         stat_set[pmcip_pkg::ST_RETRY] = term_retry;
         stat_set[pmcip_pkg::ST_DISC] = term_ok && pin.stop;
         stat_set[pmcip_pkg::ST_LATTMO] = (lat_r != 8'h00) && (wait_cnt_r == lat_r);
      end
      if (lr && (st_r != pmcip_pkg::ST_IDLE)) begin
         stat_set[pmcip_pkg::ST_PERR] = pin.perr;
         stat_set[pmcip_pkg::ST_SERR] = pin.serr;
      end
      stat_clr = (reg_wr && (reg_addr == pmcip_pkg::ADR_STAT)) ? reg_wdata[pmcip_pkg::STAT_W-1:0] : '0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Proxy registers; address and data are frozen while a cycle runs
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         data_r <= pmcip_pkg::WORD_ZERO;
         addr_r <= pmcip_pkg::WORD_ZERO;
         type_r <= pmcip_pkg::TYPE_CFG;
         rd_r <= 1'b0;
         code_r <= pmcip_pkg::CODE_CFG_WR;
         be_n_r <= pmcip_pkg::BE_N_NONE;
         ready_r <= 1'b1;
         lat_r <= pmcip_pkg::LAT_RESET;
      end else begin
         if (reg_wr && ready_r && (reg_addr == pmcip_pkg::ADR_DATA)) begin
            data_r <= reg_wdata;
         end
         if (reg_wr && ready_r && (reg_addr == pmcip_pkg::ADR_ADDR)) begin
            addr_r <= reg_wdata;
         end
         if (reg_wr && (reg_addr == pmcip_pkg::ADR_LAT)) begin
            lat_r <= reg_wdata[7:0];
         end
         if (start) begin
            type_r <= reg_wdata[pmcip_pkg::CMD_TYPE_BIT];
            rd_r <= reg_wdata[pmcip_pkg::CMD_RDWR_BIT];
            code_r <= enc_code;
            be_n_r <= enc_be_n;
            ready_r <= 1'b0;
         end
         if (fin) begin
            ready_r <= 1'b1;
            if (rd_r && term_ok) begin
               data_r <= pin.ad;
            end
         end
      end
   end

   // Sticky error flags; a new event beats a clear in the same cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stat_r <= '0;
      end else begin
         stat_r <= (stat_r & ~stat_clr) | stat_set;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port: data stand only in the cycle after the strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= pmcip_pkg::WORD_ZERO;
      end else if (reg_rd) begin
         unique case (reg_addr)
            pmcip_pkg::ADR_CMD: begin
               reg_rdata <= {ready_r, 22'h0, type_r, ~be_n_r, 3'h0, rd_r};
            end
            pmcip_pkg::ADR_DATA: reg_rdata <= data_r;
            pmcip_pkg::ADR_ADDR: reg_rdata <= addr_r;
            pmcip_pkg::ADR_STAT: reg_rdata <= {24'h0, stat_r};
            pmcip_pkg::ADR_LAT: reg_rdata <= {24'h0, lat_r};
            default: reg_rdata <= pmcip_pkg::WORD_ZERO;
         endcase
      end else begin
         reg_rdata <= pmcip_pkg::WORD_ZERO;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus sequencer; request follows the command on the fast clock,
   // every pin change after that waits for a link clock rise
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_r <= pmcip_pkg::ST_IDLE;
         req_r <= 1'b0;
         frame_line_o <= 1'b1;
         frame_line_oe_n <= 1'b1;
         initiator_ready_line_o <= 1'b1;
         initiator_ready_line_oe_n <= 1'b1;
         ad_o <= pmcip_pkg::WORD_ZERO;
         ad_oe_n <= 1'b1;
         command_byte_enable_lines_o <= pmcip_pkg::BE_N_NONE;
         command_byte_enable_lines_oe_n <= 1'b1;
         wait_cnt_r <= 8'h00;
      end else begin
         unique case (st_r)
            pmcip_pkg::ST_IDLE: begin
               if (start) begin
                  req_r <= 1'b1;
                  st_r <= pmcip_pkg::ST_REQ;
               end
            end
            pmcip_pkg::ST_REQ: begin
               // Irdy may still be driven high when a command cut the end state short
               if (lr) begin
                  initiator_ready_line_oe_n <= 1'b1;
               end
               // Wait for grant with the bus idle before taking it
               if (lr && pin.gnt && pin.bus_idle) begin
                  req_r <= 1'b0;
                  frame_line_o <= 1'b0;
                  frame_line_oe_n <= 1'b0;
                  ad_o <= addr_r;
                  ad_oe_n <= 1'b0;
                  command_byte_enable_lines_o <= code_r;
                  command_byte_enable_lines_oe_n <= 1'b0;
                  st_r <= pmcip_pkg::ST_ADDR;
               end
            end
            pmcip_pkg::ST_ADDR: begin
               if (lr) begin
                  frame_line_o <= 1'b1;
                  initiator_ready_line_o <= 1'b0;
                  initiator_ready_line_oe_n <= 1'b0;
                  command_byte_enable_lines_o <= be_n_r;
                  ad_o <= rd_r ? pmcip_pkg::WORD_ZERO : data_r;
                  ad_oe_n <= rd_r; // Turnaround for the target on reads
                  wait_cnt_r <= 8'h00;
                  st_r <= pmcip_pkg::ST_DATA;
               end
            end
            pmcip_pkg::ST_DATA: begin
               // Irdy stays low; only the target may stretch the phase
               if (fin) begin
                  initiator_ready_line_o <= 1'b1;
                  frame_line_oe_n <= 1'b1;
                  ad_oe_n <= 1'b1;
                  command_byte_enable_lines_oe_n <= 1'b1;
                  st_r <= pmcip_pkg::ST_END;
               end else if (lr && (wait_cnt_r != pmcip_pkg::WAIT_MAX)) begin
                  wait_cnt_r <= wait_cnt_r + 8'h01;
               end
            end
            pmcip_pkg::ST_END: begin
               // Irdy was driven high for one link cycle before release
               if (lr) begin
                  initiator_ready_line_oe_n <= 1'b1;
               end
               // Ready is already set here, so a command must not be lost
               if (start) begin
                  req_r <= 1'b1;
                  st_r <= pmcip_pkg::ST_REQ;
               end else if (lr) begin
                  st_r <= pmcip_pkg::ST_IDLE;
               end
            end
            default: st_r <= pmcip_pkg::ST_IDLE;
         endcase
      end
   end

   assign bus_request_out_n = ~req_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks on the sequencer
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_addr_phase;
      (st_r == pmcip_pkg::ST_ADDR) && !frame_line_o && !frame_line_oe_n;
   endsequence

   sequence s_data_phase;
      (st_r == pmcip_pkg::ST_DATA) && frame_line_o && !initiator_ready_line_o;
   endsequence

   a_req_after_cmd: assert property (start |=> !bus_request_out_n && !ready_r) else $error("request late");
   a_cfg_wr_code: assert property (s_addr_phase ##0 (!type_r && !rd_r) |->
      command_byte_enable_lines_o == pmcip_pkg::CODE_CFG_WR) else $error("bad cfg write code");
   a_cfg_rd_code: assert property (s_addr_phase ##0 (!type_r && rd_r) |->
      command_byte_enable_lines_o == pmcip_pkg::CODE_CFG_RD) else $error("bad cfg read code");
   a_io_wr_code: assert property (s_addr_phase ##0 (type_r && !rd_r) |->
      command_byte_enable_lines_o == pmcip_pkg::CODE_IO_WR) else $error("bad io write code");
   a_io_rd_code: assert property (s_addr_phase ##0 (type_r && rd_r) |->
      command_byte_enable_lines_o == pmcip_pkg::CODE_IO_RD) else $error("bad io read code");
   a_addr_on_ad: assert property (s_addr_phase |-> ad_o == addr_r && !ad_oe_n) else $error("bad address");
   a_one_data_phase: assert property (s_addr_phase ##0 lr |=> s_data_phase ##0
      (rd_r || ad_o == data_r)) else $error("data phase not entered");
   a_no_init_wait: assert property (s_data_phase ##0 !fin |=> s_data_phase) else $error("irdy dropped");
   a_ready_on_done: assert property (fin |=> ready_r && st_r == pmcip_pkg::ST_END) else $error("no ready");
   a_read_capture: assert property (fin && rd_r && term_ok |=> data_r == $past(pin.ad)) else $error("no read data");
   a_master_abort: assert property (lr && st_r == pmcip_pkg::ST_DATA && ma_hit && !pin.stop |=>
      stat_r[pmcip_pkg::ST_MABORT]) else $error("master abort lost");
endmodule

// ### dv/pmcip_target_model.sv
// Behavioural PCI arbiter and single target answering the proxy cycles
`timescale 1ns/1ps
module pmcip_target_model (
   input wire logic pci_clk,
   input wire logic req_n,
   input wire logic frame_w,
   input wire logic irdy_w,
   input wire logic [31:0] ad_w,
   input wire logic [3:0] cbe_w,
   input wire logic [1:0] mode,
   input wire logic [3:0] waits,
   input wire logic [31:0] rd_data,
   output logic gnt_n = 1'b1,
   output logic devsel_n = 1'b1,
   output logic trdy_n = 1'b1,
   output logic stop_n = 1'b1,
   output logic [31:0] ad_t = 32'h0,
   output logic ad_t_en = 1'b0,
   output logic [31:0] got_addr,
   output logic [31:0] got_data,
   output logic [3:0] got_cmd,
   output logic [3:0] got_be
);
   logic act = 1'b0;
   logic rd = 1'b0;
   int cnt = 0;
   ////////////////////////////////////////////////////////////////////////
   // Phases are judged at the rising link edge, as a real target does
   always @(posedge pci_clk) begin
      if (!frame_w && !act) begin
         act <= 1'b1;
         cnt <= 0;
         rd <= !cbe_w[0];
         got_addr <= ad_w;
         got_cmd <= cbe_w;
      end else if (act && !irdy_w) begin
         if (!trdy_n || !stop_n) begin
            act <= 1'b0;
            got_be <= cbe_w;
            if (!rd) got_data <= ad_w;
         end else begin
            cnt <= cnt + 1;
         end
      end else if (act && frame_w && irdy_w && cnt > 0) begin
         act <= 1'b0; // Initiator gave up, as after a master abort
      end
   end
   // Answers move mid-cycle so they are settled at the next rising edge
   // Mode 0 completes, mode 1 never claims the cycle, mode 2 asks for retry
   always @(negedge pci_clk) begin
      gnt_n <= req_n;
      devsel_n <= !(act && mode != 2'h1 && cnt > 0);
      trdy_n <= !(act && mode == 2'h0 && cnt > waits);
      stop_n <= !(act && mode == 2'h2 && cnt > waits);
      ad_t_en <= act && rd && mode != 2'h1 && cnt > 0; // An unclaimed cycle leaves AD floating
      ad_t <= rd_data;
   end
endmodule

// ### dv/test_pci_master_cfg_io_proxy.sv
// Self-checking bench for the proxy engine against a behavioural target
`timescale 1ns/1ps
module test_pci_master_cfg_io_proxy;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic pci_clk = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata, ad_o, ad_t, ad_i, got_addr, got_data;
   logic [31:0] rd_data = 32'h0;
   logic [31:0] float_pat = 32'hA5A5_5A5A;
   logic gnt_n, req_n, frame_o, frame_oe_n, irdy_o, irdy_oe_n, devsel_n, trdy_n, stop_n, ad_oe_n, cbe_oe_n, ad_t_en;
   logic frame_w, irdy_w;
   logic [3:0] cbe_o, cbe_w, got_cmd, got_be;
   logic [3:0] waits = 4'h0;
   logic [1:0] mode = 2'h0;
   logic perr_n = 1'b1;
   logic serr_n = 1'b1;
   int fails = 0;
   int samples_checked = 0;
   ////////////////////////////////////////////////////////////////////////
   // Clocks; the link clock runs free with an unrelated phase
   initial forever #4 clk = ~clk;
   initial begin
      #37;
      forever #80 pci_clk = ~pci_clk;
   end
   // Released frame and irdy float high through pull-ups; released AD and C/BE lines keep moving
   always @(posedge pci_clk) float_pat <= ~float_pat;
   assign frame_w = frame_oe_n ? 1'b1 : frame_o;
   assign irdy_w = irdy_oe_n ? 1'b1 : irdy_o;
   assign cbe_w = cbe_oe_n ? float_pat[3:0] : cbe_o;
   assign ad_i = !ad_oe_n ? ad_o : (ad_t_en ? ad_t : float_pat);
   pmcip_top uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pci_clk_in(pci_clk), .bus_grant_in_n(gnt_n),
      .bus_request_out_n(req_n), .frame_line_i(frame_w), .frame_line_o(frame_o), .frame_line_oe_n(frame_oe_n),
      .initiator_ready_line_i(irdy_w), .initiator_ready_line_o(irdy_o), .initiator_ready_line_oe_n(irdy_oe_n),
      .target_ready_line_n(trdy_n), .devsel_line_n(devsel_n), .stop_line_n(stop_n), .parity_error_line_n(perr_n),
      .system_error_line_n(serr_n), .ad_i(ad_i), .ad_o(ad_o), .ad_oe_n(ad_oe_n),
      .command_byte_enable_lines_o(cbe_o), .command_byte_enable_lines_oe_n(cbe_oe_n));
   pmcip_target_model partner (.pci_clk(pci_clk), .req_n(req_n), .frame_w(frame_w), .irdy_w(irdy_w), .ad_w(ad_i),
      .cbe_w(cbe_w), .mode(mode), .waits(waits), .rd_data(rd_data), .gnt_n(gnt_n), .devsel_n(devsel_n),
      .trdy_n(trdy_n), .stop_n(stop_n), .ad_t(ad_t), .ad_t_en(ad_t_en), .got_addr(got_addr),
      .got_data(got_data), .got_cmd(got_cmd), .got_be(got_be));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: register %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: bus %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // Bounded poll so a lost completion ends as a mismatch, not a hang
   task automatic wait_ready;
      logic [31:0] v;
      v = 32'h0;
      for (int i = 0; i < 600 && v[31] !== 1'b1; i++) rd(pmcip_pkg::ADR_CMD, v);
      chk_reg({31'h0, v[31]}, 32'h1);
   endtask
   // One proxied cycle; st is the status expected once it ends
   task automatic xfer(input logic io, input logic rdn, input logic [31:0] a, input logic [3:0] be,
         input logic [31:0] d, input logic [7:0] st);
      logic [31:0] v;
      logic [3:0] code;
      code = io ? (rdn ? 4'h2 : 4'h3) : (rdn ? 4'hA : 4'hB);
      rd_data = d;
      if (!rdn) wr(pmcip_pkg::ADR_DATA, d);
      wr(pmcip_pkg::ADR_ADDR, a);
      wr(pmcip_pkg::ADR_CMD, {23'h0, io, be, 3'h0, rdn});
      @(posedge clk);
      #1 chk_bus({31'h0, req_n}, 32'h0);
      wait_ready;
      rd(pmcip_pkg::ADR_STAT, v);
      chk_reg(v, {24'h0, st});
      wr(pmcip_pkg::ADR_STAT, 32'hFF);
      if (st == 8'h00) begin
         chk_bus({28'h0, got_cmd}, {28'h0, code});
         chk_bus(got_addr, a);
         chk_bus({28'h0, got_be}, {28'h0, ~be});
         if (!rdn) chk_bus(got_data, d);
         rd(pmcip_pkg::ADR_DATA, v);
         chk_reg(v, d);
      end
   endtask
   task automatic results;
      if (fails == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #400_000;
      fails++;
      results;
   end
   // Main sequence: reset state, all four cycle kinds, an enable refusal, a master abort and a retry
   initial begin
      logic [31:0] v, a;
      logic [3:0] be;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      #1 chk_bus({29'h0, req_n, frame_oe_n, ad_oe_n}, 32'h7);
      rd(pmcip_pkg::ADR_CMD, v);
      chk_reg({31'h0, v[31]}, 32'h1);
      rd(pmcip_pkg::ADR_LAT, v);
      chk_reg(v, 32'h20);
      rd(8'h14, v);
      chk_reg(v, 32'h0);
      void'($urandom(13));
      for (int i = 0; i < 12; i++) begin
         a = $urandom;
         waits = 4'($urandom_range(3));
         if (i[1]) begin
            be = 4'($urandom << a[1:0]) | 4'(1 << a[1:0]);
         end else begin
            a[1] = 1'b0;
            be = 4'($urandom);
         end
         xfer(i[1], i[0], a, be, $urandom, 8'h00);
      end
      wr(pmcip_pkg::ADR_ADDR, 32'h0000_1001);
      wr(pmcip_pkg::ADR_CMD, 32'h0000_0111);
      @(posedge clk);
      #1 chk_bus({31'h0, req_n}, 32'h1);
      rd(pmcip_pkg::ADR_STAT, v);
      chk_reg(v, 32'h80);
      wr(pmcip_pkg::ADR_STAT, 32'hFF);
      mode = 2'h1;
      xfer(1'b0, 1'b1, 32'h0000_0800, 4'hF, 32'h1234_5678, 8'h01);
      mode = 2'h2;
      xfer(1'b1, 1'b0, 32'h0000_0300, 4'h3, 32'h9ABC_DEF0, 8'h04);
      mode = 2'h0;
      // Parity and system error lines held low through a whole cycle
      perr_n <= 1'b0;
      serr_n <= 1'b0;
      xfer(1'b1, 1'b1, 32'h0000_0402, 4'hC, 32'h55AA_33CC, 8'h60);
      perr_n <= 1'b1;
      serr_n <= 1'b1;
      repeat (40) @(posedge clk);
      wr(pmcip_pkg::ADR_STAT, 32'hFF);
      rd(pmcip_pkg::ADR_STAT, v);
      chk_reg(v, 32'h0);
      xfer(1'b0, 1'b0, 32'h0000_0C01, 4'h5, 32'h0F0F_F0F0, 8'h00);
      results;
   end
endmodule
